//--- ecm_pkg.sv
// Purpose: shared constants and types of the capture/compare/pwm mode-select unit
// Assumes: 32-bit axi4-lite register bus, word-aligned registers
// Notes: register offsets are byte addresses
`default_nettype none
package ecm_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_DUTY_HI = 8'h04;
	localparam logic [7:0] OFF_COMPARE = 8'h08;
	localparam logic [7:0] OFF_CAPTURE = 8'h0C;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [7:0] OFF_MASK = 8'h14;
	localparam int ADDR_W = 8;
	// field positions inside the control register
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_DC_LSB = 4;
	localparam int CTRL_CFG_LSB = 6;
	localparam int CTRL_W = 8;
	// reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] DUTY_HI_RST = 8'h00;
	localparam logic [15:0] COMPARE_RST = 16'hFFFF;
	// mode codes
	localparam logic [3:0] MODE_OFF = 4'h0;
	localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
	localparam logic [3:0] MODE_CAP_FALL = 4'h4;
	localparam logic [3:0] MODE_CAP_RISE = 4'h5;
	localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
	localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
	localparam logic [3:0] MODE_CMP_SET = 4'h8;
	localparam logic [3:0] MODE_CMP_CLR = 4'h9;
	localparam logic [3:0] MODE_CMP_SOFT = 4'hA;
	localparam logic [3:0] MODE_CMP_SPECIAL = 4'hB;
	localparam logic [1:0] MODE_PWM_TOP = 2'h3;
	// output configuration codes in pwm mode
	localparam logic [1:0] CFG_SINGLE = 2'h0;
	localparam logic [1:0] CFG_FULL_FWD = 2'h1;
	localparam logic [1:0] CFG_HALF = 2'h2;
	localparam logic [1:0] CFG_FULL_REV = 2'h3;
	// prescaler terminal counts
	localparam logic [3:0] PRESC_4_LAST = 4'h3;
	localparam logic [3:0] PRESC_16_LAST = 4'hF;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// clock
	localparam int CLK_PERIOD_NS = 100;

	typedef struct packed {
		logic [1:0] output_config_select;
		logic [1:0] pwm_duty_low_bits;
		logic [3:0] unit_mode_select;
	} ecm_ctrl_t;

	typedef struct packed {
		logic d;
		logic c;
		logic b;
		logic a;
	} ecm_pins_t;
endpackage
`default_nettype wire

//--- ecm_cap_presc.sv
// Purpose: qualifies capture edges by mode, with rising-edge prescaler
// Assumes: edge inputs are one-cycle pulses in the aclk domain
// Notes: counter restarts on clear
`timescale 1ns/100ps
`default_nettype none
module ecm_cap_presc
(
	input wire logic aclk, // clock
	input wire logic aresetn, // sync reset, active low
	input wire logic clear, // restart prescaler
	input wire logic [3:0] mode, // unit mode select
	input wire logic edge_rise, // rising edge pulse
	input wire logic edge_fall, // falling edge pulse
	output logic cap_event // qualifying capture pulse
);
	logic [3:0] cnt_r;

	always_ff @(posedge aclk)
	begin
		if (!aresetn || clear)
			cnt_r <= 4'h0;
		else if (edge_rise)
			cnt_r <= cnt_r + 4'h1;
	end

	always_comb
	begin
		unique case (mode)
			ecm_pkg::MODE_CAP_FALL: cap_event = edge_fall;
			ecm_pkg::MODE_CAP_RISE: cap_event = edge_rise;
			ecm_pkg::MODE_CAP_RISE4:
				cap_event = edge_rise && (cnt_r[1:0] == ecm_pkg::PRESC_4_LAST[1:0]);
			ecm_pkg::MODE_CAP_RISE16:
				cap_event = edge_rise && (cnt_r == ecm_pkg::PRESC_16_LAST);
			default: cap_event = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

//--- ecm_unit.sv
// Purpose: mode decode, capture, compare and bridge pwm outputs with axi4-lite registers
// Assumes: timer value and pin inputs synchronous to aclk
// Notes: output enables are low while a pin is driven
//
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module ecm_unit
(
	input wire logic aclk, // clock, 10 MHz
	input wire logic aresetn, // sync reset, active low
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic [15:0] tmr_val, // time base count
	input wire logic pin_a_i, // bridge pin a level, capture input
	output ecm_pkg::ecm_pins_t pin_o, // bridge pin levels
	output ecm_pkg::ecm_pins_t pin_oe_n, // bridge pin enables, low drives
	output logic tmr_reset, // timer reset pulse
	output logic irq // interrupt level
);
	ecm_pkg::ecm_ctrl_t ctrl_r;
	logic [7:0] duty_hi_r;
	logic [15:0] cmp_r;
	logic [15:0] cap_r;
	logic status_r;
	logic mask_r;
	logic [3:0] mode_prev_r;
	logic match_d_r;
	logic pin_a_d_r;
	logic cmp_pin_r;
	logic pwm_d_r;
	logic [31:0] rdata_nxt;
	logic rd_ok;
	logic wr_ok;
	logic wr_go;
	logic rd_go;
	logic [3:0] mode;
	logic mode_entry;
	logic match_p;
	logic cap_event;
	logic cmp_event;
	logic evt;
	logic [9:0] duty10;
	logic pwm_m;
	logic pwm_mode;
	ecm_pkg::ecm_pins_t act;
	ecm_pkg::ecm_pins_t pin_nxt;
	ecm_pkg::ecm_pins_t oe_n_nxt;

	assign mode = ctrl_r.unit_mode_select;
	assign mode_entry = (mode != mode_prev_r);
	assign pwm_mode = (mode[3:2] == ecm_pkg::MODE_PWM_TOP);
	assign match_p = (tmr_val == cmp_r) && !match_d_r;

	////////////////////////////////////////////////////////////////////////////
	// register bus
	assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
	assign rd_go = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;

	always_comb
	begin
		wr_ok = 1'b1;
		unique case (s_axi_awaddr)
			ecm_pkg::OFF_CTRL, ecm_pkg::OFF_DUTY_HI, ecm_pkg::OFF_COMPARE,
			ecm_pkg::OFF_CAPTURE, ecm_pkg::OFF_STATUS, ecm_pkg::OFF_MASK: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	always_comb
	begin
		rd_ok = 1'b1;
		rdata_nxt = 32'h0000_0000;
		unique case (s_axi_araddr)
			ecm_pkg::OFF_CTRL: rdata_nxt[7:0] = ctrl_r;
			ecm_pkg::OFF_DUTY_HI: rdata_nxt[7:0] = duty_hi_r;
			ecm_pkg::OFF_COMPARE: rdata_nxt[15:0] = cmp_r;
			ecm_pkg::OFF_CAPTURE: rdata_nxt[15:0] = cap_r;
			ecm_pkg::OFF_STATUS: rdata_nxt[0] = status_r;
			ecm_pkg::OFF_MASK: rdata_nxt[0] = mask_r;
			default: rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= ecm_pkg::RESP_OKAY;
		end
		else
		begin
			s_axi_awready <= wr_go;
			s_axi_wready <= wr_go;
			if (wr_go)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? ecm_pkg::RESP_OKAY : ecm_pkg::RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= ecm_pkg::RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= rd_go;
			if (rd_go)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rdata_nxt;
				s_axi_rresp <= rd_ok ? ecm_pkg::RESP_OKAY : ecm_pkg::RESP_SLVERR;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// software-written registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_r <= ecm_pkg::CTRL_RST;
			duty_hi_r <= ecm_pkg::DUTY_HI_RST;
			cmp_r <= ecm_pkg::COMPARE_RST;
			mask_r <= 1'b0;
		end
		else if (wr_go && s_axi_wstrb[0])
		begin
			unique case (s_axi_awaddr)
				ecm_pkg::OFF_CTRL: ctrl_r <= s_axi_wdata[7:0];
				ecm_pkg::OFF_DUTY_HI: duty_hi_r <= s_axi_wdata[7:0];
				ecm_pkg::OFF_COMPARE: cmp_r[7:0] <= s_axi_wdata[7:0];
				ecm_pkg::OFF_MASK: mask_r <= s_axi_wdata[0];
				default: ;
			endcase
			if (s_axi_awaddr == ecm_pkg::OFF_COMPARE && s_axi_wstrb[1])
				cmp_r[15:8] <= s_axi_wdata[15:8];
		end
		else if (wr_go && s_axi_wstrb[1] && s_axi_awaddr == ecm_pkg::OFF_COMPARE)
			cmp_r[15:8] <= s_axi_wdata[15:8];
	end

	////////////////////////////////////////////////////////////////////////////
	// events, status and interrupt
	assign cmp_event = match_p && (mode == ecm_pkg::MODE_CMP_TOGGLE || mode[3:2] == 2'h2);
	assign evt = cmp_event || cap_event;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			status_r <= 1'b0;
		else if (evt)
			status_r <= 1'b1;
		else if (rd_go && s_axi_araddr == ecm_pkg::OFF_STATUS)
			status_r <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			irq <= 1'b0;
		else
			irq <= status_r && mask_r;
	end

	////////////////////////////////////////////////////////////////////////////
	// capture path
	ecm_cap_presc u_presc
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.clear(mode_entry),
		.mode(mode),
		.edge_rise(pin_a_i && !pin_a_d_r),
		.edge_fall(!pin_a_i && pin_a_d_r),
		.cap_event(cap_event)
	);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mode_prev_r <= ecm_pkg::MODE_OFF;
			match_d_r <= 1'b0;
			pin_a_d_r <= 1'b0;
		end
		else
		begin
			mode_prev_r <= mode;
			match_d_r <= (tmr_val == cmp_r);
			pin_a_d_r <= pin_a_i;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || mode == ecm_pkg::MODE_OFF)
			cap_r <= 16'h0000;
		else if (cap_event)
			cap_r <= tmr_val;
	end

	////////////////////////////////////////////////////////////////////////////
	// compare path
	always_ff @(posedge aclk)
	begin
		if (!aresetn || mode == ecm_pkg::MODE_OFF)
			cmp_pin_r <= 1'b0;
		else if (mode_entry && mode == ecm_pkg::MODE_CMP_CLR)
			cmp_pin_r <= 1'b1;
		else if (mode_entry && mode == ecm_pkg::MODE_CMP_SET)
			cmp_pin_r <= 1'b0;
		else if (match_p && mode == ecm_pkg::MODE_CMP_CLR)
			cmp_pin_r <= 1'b0;
		else if (match_p && mode == ecm_pkg::MODE_CMP_SET)
			cmp_pin_r <= 1'b1;
		else if (match_p && mode == ecm_pkg::MODE_CMP_TOGGLE)
			cmp_pin_r <= !cmp_pin_r;
	end

	// special event resets the timer and sets the event flag, no conversion start
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			tmr_reset <= 1'b0;
		else
			tmr_reset <= match_p && mode == ecm_pkg::MODE_CMP_SPECIAL;
	end

	////////////////////////////////////////////////////////////////////////////
	// pwm and pin steering
	assign duty10 = {duty_hi_r, ctrl_r.pwm_duty_low_bits};
	assign pwm_m = (tmr_val[9:0] < duty10);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pwm_d_r <= 1'b0;
		else
			pwm_d_r <= pwm_m;
	end

	always_comb
	begin
		act = 4'h0;
		oe_n_nxt = 4'hF;
		unique case (ctrl_r.output_config_select)
			ecm_pkg::CFG_SINGLE:
			begin
				act = {4{pwm_m}};
				oe_n_nxt = 4'h0;
			end
			ecm_pkg::CFG_HALF:
			begin
				act.a = pwm_m && pwm_d_r;
				act.b = !pwm_m && !pwm_d_r;
				oe_n_nxt = 4'hC;
			end
			ecm_pkg::CFG_FULL_FWD:
			begin
				act.d = pwm_m;
				act.a = 1'b1;
				oe_n_nxt = 4'h0;
			end
			ecm_pkg::CFG_FULL_REV:
			begin
				act.b = pwm_m;
				act.c = 1'b1;
				oe_n_nxt = 4'h0;
			end
		endcase
		pin_nxt.a = act.a ^ mode[1];
		pin_nxt.c = act.c ^ mode[1];
		pin_nxt.b = act.b ^ mode[0];
		pin_nxt.d = act.d ^ mode[0];
		if (!pwm_mode)
		begin
			pin_nxt = {3'h0, cmp_pin_r};
			oe_n_nxt = 4'hF;
			if (mode == ecm_pkg::MODE_CMP_TOGGLE || mode == ecm_pkg::MODE_CMP_SET
				|| mode == ecm_pkg::MODE_CMP_CLR)
				oe_n_nxt.a = 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pin_o <= 4'h0;
			pin_oe_n <= 4'hF;
		end
		else
		begin
			pin_o <= pin_nxt;
			pin_oe_n <= oe_n_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	a_special_reset: assert property (@(posedge aclk) disable iff (!aresetn)
		tmr_reset |-> $past(mode) == ecm_pkg::MODE_CMP_SPECIAL && status_r)
		else $error("timer reset without special event");
	a_soft_undriven: assert property (@(posedge aclk) disable iff (!aresetn)
		mode == ecm_pkg::MODE_CMP_SOFT && match_p |=> pin_oe_n.a && status_r)
		else $error("soft compare drove pin or lost flag");
	a_entry_high: assert property (@(posedge aclk) disable iff (!aresetn)
		mode_entry && mode == ecm_pkg::MODE_CMP_CLR |=> ##1 pin_o.a && !pin_oe_n.a)
		else $error("pin not high on entry");
	a_entry_low: assert property (@(posedge aclk) disable iff (!aresetn)
		mode_entry && mode == ecm_pkg::MODE_CMP_SET |=> ##1 !pin_o.a)
		else $error("pin not low on entry");
	a_toggle_pin: assert property (@(posedge aclk) disable iff (!aresetn)
		mode == ecm_pkg::MODE_CMP_TOGGLE && !mode_entry && match_p
		|=> cmp_pin_r != $past(cmp_pin_r))
		else $error("pin not toggled on match");
	a_capture_value: assert property (@(posedge aclk) disable iff (!aresetn)
		cap_event && mode != ecm_pkg::MODE_OFF |=> cap_r == $past(tmr_val) && status_r)
		else $error("capture value or flag wrong");
	a_off_reset: assert property (@(posedge aclk) disable iff (!aresetn)
		mode == ecm_pkg::MODE_OFF |=> cap_r == 16'h0000 && !cmp_pin_r)
		else $error("disabled unit kept state");
	a_half_ports: assert property (@(posedge aclk) disable iff (!aresetn)
		pwm_mode && ctrl_r.output_config_select == ecm_pkg::CFG_HALF
		|=> pin_oe_n == 4'hC)
		else $error("half bridge enables wrong");
	a_pwm_polarity: assert property (@(posedge aclk) disable iff (!aresetn)
		pwm_mode && ctrl_r.output_config_select == ecm_pkg::CFG_FULL_FWD
		|=> pin_o.a == !$past(mode[1]))
		else $error("active level of pin a wrong");
	a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
		irq == $past(status_r && mask_r))
		else $error("interrupt level mismatch");
endmodule
`default_nettype wire

//--- ecm_far_end.sv
// Purpose: bridge-side model, time base and pin a source
// Assumes: single clock, bench steers load, run and source level
// Notes: released pin a follows the external source
`timescale 1ns/100ps
`default_nettype none
module ecm_far_end
(
	input wire logic aclk, // clock
	input wire logic aresetn, // sync reset, active low
	input wire logic run, // timer counts
	input wire logic ld, // timer load strobe
	input wire logic [15:0] ld_val, // timer load value
	input wire logic ext_a, // external source on pin a
	input wire logic tmr_reset, // special event reset
	input wire ecm_pkg::ecm_pins_t pin_o, // driven levels
	input wire ecm_pkg::ecm_pins_t pin_oe_n, // enables, low drives
	output logic [15:0] tmr_val, // time base count
	output logic pin_a_i // resolved pin a level
);
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			tmr_val <= 16'h0000;
		else if (tmr_reset)
			tmr_val <= 16'h0000;
		else if (ld)
			tmr_val <= ld_val;
		else if (run)
			tmr_val <= tmr_val + 16'h0001;
	end
	// pin a seen by the unit: its own drive, else the outside source
	assign pin_a_i = pin_oe_n.a ? ext_a : pin_o.a;
endmodule
`default_nettype wire

//--- ecm_tb.sv
// Purpose: self-checking bench of the mode-select unit
// Assumes: bridge-side model supplies timer and pin a
// Notes: one task per scenario
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic run = 1'b0, ld = 1'b0, ext_a = 1'b0;
	logic [15:0] ld_val = 16'h0000;
	logic awready, wready, bvalid, arready, rvalid, tmr_reset, irq, pin_a_i;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [15:0] tmr_val;
	ecm_pkg::ecm_pins_t pin_o, pin_oe_n;
	int n_errors = 0, n_checks = 0, cyc = 0;
	ecm_unit uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .tmr_val(tmr_val), .pin_a_i(pin_a_i), .pin_o(pin_o),
		.pin_oe_n(pin_oe_n), .tmr_reset(tmr_reset), .irq(irq));
	ecm_far_end far (.aclk(aclk), .aresetn(aresetn), .run(run), .ld(ld), .ld_val(ld_val),
		.ext_a(ext_a), .tmr_reset(tmr_reset), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
		.tmr_val(tmr_val), .pin_a_i(pin_a_i));
	always #50 aclk = ~aclk;
	////////////////////////////////////////////////////////////////////////////////
	task automatic close_out;
		if (n_errors == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic ok, input string m);
		n_checks++;
		if (ok !== 1'b1)
		begin
			n_errors++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge aclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1 && n < 50);
		bready <= 1'b0;
		chk(bresp === er, "write response");
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (arready === 1'b1)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1 && n < 50);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string m);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(r === ecm_pkg::RESP_OKAY && d === e, m);
	endtask
	task automatic load(input logic [15:0] v, input logic go);
		@(posedge aclk);
		ld <= 1'b1;
		ld_val <= v;
		run <= go;
		@(posedge aclk);
		ld <= 1'b0;
	endtask
	task automatic pulse;
		@(posedge aclk);
		ext_a <= 1'b1;
		tick(3);
		ext_a <= 1'b0;
		tick(3);
	endtask
	function automatic logic [3:0] exp_pins(input logic [3:0] m, input logic [1:0] c,
		input logic p);
		logic [3:0] act;
		case (c)
			2'h0: act = {4{p}};
			2'h1: act = {p, 1'b0, 1'b0, 1'b1};
			2'h2: act = {1'b0, 1'b0, ~p, p};
			default: act = {1'b0, 1'b1, p, 1'b0};
		endcase
		return act ^ {m[0], m[1], m[0], m[1]};
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		logic [7:0] offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
		logic [31:0] d;
		logic [1:0] r;
		for (int i = 0; i < 6; i++)
			rdc(offs[i], (i == 2) ? 32'h0000_FFFF : 32'h0000_0000, "reset value");
		wr(8'h18, 32'h0000_00FF, ecm_pkg::RESP_SLVERR);
		rd(8'h18, d, r);
		chk(r === ecm_pkg::RESP_SLVERR && d === 32'h0000_0000, "unmapped read");
		wr(ecm_pkg::OFF_DUTY_HI, 32'h0000_1234, ecm_pkg::RESP_OKAY);
		rdc(ecm_pkg::OFF_DUTY_HI, 32'h0000_0034, "duty high readback");
	endtask
	task automatic t_capture;
		logic [3:0] modes [4] = '{4'h5, 4'h4, 4'h6, 4'h7};
		int per [4] = '{1, 1, 4, 16};
		logic [31:0] d;
		logic [1:0] r;
		for (int i = 0; i < 4; i++)
		begin
			wr(ecm_pkg::OFF_CTRL, 32'(modes[i]), ecm_pkg::RESP_OKAY);
			load(16'h1230 + 16'(i), 1'b0);
			rd(ecm_pkg::OFF_STATUS, d, r);
			repeat (per[i] - 1) pulse();
			rdc(ecm_pkg::OFF_STATUS, 32'h0000_0000, "early capture");
			pulse();
			rdc(ecm_pkg::OFF_STATUS, 32'h0000_0001, "capture flag");
			rdc(ecm_pkg::OFF_CAPTURE, 32'h0000_1230 + i, "capture value");
			chk(irq === 1'b0, "masked irq");
		end
		wr(ecm_pkg::OFF_CTRL, 32'h0000_0000, ecm_pkg::RESP_OKAY);
		rdc(ecm_pkg::OFF_CAPTURE, 32'h0000_0000, "capture cleared");
		chk(pin_oe_n === 4'hF, "pins released");
	endtask
	task automatic t_compare;
		logic [3:0] modes [5] = '{4'h8, 4'h9, 4'h2, 4'hA, 4'hB};
		logic pre;
		logic rel;
		wr(ecm_pkg::OFF_COMPARE, 32'h0000_0040, ecm_pkg::RESP_OKAY);
		wr(ecm_pkg::OFF_MASK, 32'h0000_0001, ecm_pkg::RESP_OKAY);
		for (int i = 0; i < 5; i++)
		begin
			rel = (modes[i][3:1] == 3'b101);
			load(16'h0000, 1'b0);
			wr(ecm_pkg::OFF_CTRL, 32'(modes[i]), ecm_pkg::RESP_OKAY);
			tick(4);
			pre = pin_o.a;
			chk(pin_oe_n.a === rel, "pin a release");
			if (modes[i][3:1] == 3'b100)
				chk(pre === modes[i][0], "entry level");
			load(16'h0036, 1'b1);
			while (irq !== 1'b1 && cyc < 19000)
				@(posedge aclk);
			chk(irq === 1'b1, "irq raised");
			chk(rel || pin_o.a === ~pre, "match level");
			chk((tmr_val < 16'h0040) === (modes[i] == 4'hB), "timer reset");
			run <= 1'b0;
			rdc(ecm_pkg::OFF_STATUS, 32'h0000_0001, "event flag");
			tick(3);
			chk(irq === 1'b0, "irq cleared");
		end
	endtask
	task automatic t_reserved;
		for (int i = 1; i < 4; i += 2)
		begin
			wr(ecm_pkg::OFF_CTRL, 32'(i), ecm_pkg::RESP_OKAY);
			load(16'h003B, 1'b1);
			pulse();
			pulse();
			run <= 1'b0;
			chk(pin_oe_n === 4'hF && irq === 1'b0, "reserved pins");
			rdc(ecm_pkg::OFF_STATUS, 32'h0000_0000, "reserved event");
		end
	endtask
	task automatic t_pwm;
		logic [3:0] eoe;
		wr(ecm_pkg::OFF_DUTY_HI, 32'h0000_0010, ecm_pkg::RESP_OKAY);
		for (int m = 12; m < 16; m++)
			for (int c = 0; c < 4; c++)
			begin
				eoe = (c == 2) ? 4'hC : 4'h0;
				wr(ecm_pkg::OFF_CTRL, 32'({2'(c), 2'b01, 4'(m)}), ecm_pkg::RESP_OKAY);
				for (int p = 0; p < 2; p++)
				begin
					load(p ? 16'h0040 : 16'h0041, 1'b0);
					tick(4);
					chk(((pin_o ^ exp_pins(4'(m), 2'(c), p[0])) & ~eoe) === 4'h0, "pwm level");
					chk(pin_oe_n === eoe, "pwm enables");
				end
			end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_errors++;
			close_out();
		end
	end
	initial
	begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_capture();
		t_compare();
		t_reserved();
		t_pwm();
		close_out();
	end
endmodule
`default_nettype wire
